//--- rtl/mrf_regs.sv
// Rate, fault queue, fan behaviour and first interrupt mask registers of the monitor.
// Assumes the bus engine presents one-cycle byte writes and a read address on the same clock;
// lock and soft restore come from the configuration registers on the same clock.
`timescale 1ns/1ns
`include "mrf_params.svh"
module mrf_regs
    import mrf_pkg::*;
#(
    parameter int SLOW_PERIOD_CYC = `MRF_SLOW_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // Register port from the bus engine
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // Global controls held elsewhere
    input  wire logic       lock_i,
    input  wire logic       soft_restore_i,
    // Measurement sequencer
    input  wire logic       round_start_i,
    input  wire logic       meas_done_i,
    input  wire logic       meas_out_i,
    output logic      [3:0] active_rate_o,
    output logic            conv_tick_o,
    // Alert qualification
    output logic      [2:0] fault_need_o,
    output logic            fault_alert_o,
    // Interrupt status: local high, local low, remote high, remote low, diode error
    input  wire logic [4:0] status_i,
    output logic            int_o,
    // Fan drive
    input  wire logic [7:0] local_speed_i,
    input  wire logic [7:0] remote_speed_i,
    output logic      [7:0] fan_drive_o
);

    // Priority decode of the queue field into a count of one to four
    function automatic logic [2:0] queue_need(input logic [3:0] q);
        if (q[3]) begin
            return 3'd4;
        end else if (q[2]) begin
            return 3'd3;
        end else if (q[1]) begin
            return 3'd2;
        end else begin
            return 3'd1;
        end
    endfunction

    mrf_byte_type      rate_r;
    mrf_byte_type      queue_r;
    mrf_byte_type      fan_r;
    mrf_byte_type      mask_r;
    mrf_byte_type      rdata_r;
    logic        [2:0] fault_cnt_r;
    logic              int_r;
    logic        [7:0] drive_r;

    logic              wr_rate;
    logic              wr_queue;
    logic              wr_fan;
    logic              wr_mask;
    logic        [2:0] need_w;
    logic              fan_off_w;
    mrf_drive_sel_type sel_w;
    logic        [7:0] drive_nxt;
    logic        [7:0] rd_mux;
    logic              int_nxt;

    // Lockable registers drop writes while locked; the mask is never locked
    assign wr_rate  = reg_wr_i && !lock_i && (reg_addr_i == `MRF_ADDR_RATE);
    assign wr_queue = reg_wr_i && !lock_i && (reg_addr_i == `MRF_ADDR_QUEUE);
    assign wr_fan   = reg_wr_i && !lock_i && (reg_addr_i == `MRF_ADDR_FAN);
    assign wr_mask  = reg_wr_i && (reg_addr_i == `MRF_ADDR_MASK);

    // Soft restore wins over a write in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rate_r  <= `MRF_RST_RATE;
            queue_r <= `MRF_RST_QUEUE;
            fan_r   <= `MRF_RST_FAN;
            mask_r  <= `MRF_RST_MASK;
        end else if (soft_restore_i) begin
            rate_r  <= `MRF_RST_RATE;
            queue_r <= `MRF_RST_QUEUE;
            fan_r   <= `MRF_RST_FAN;
            mask_r  <= `MRF_RST_MASK;
        end else begin
            if (wr_rate) begin
                rate_r  <= (reg_wdata_i & `MRF_WMASK_RATE) | (rate_r & ~`MRF_WMASK_RATE);
            end
            if (wr_queue) begin
                queue_r <= (reg_wdata_i & `MRF_WMASK_QUEUE) | (queue_r & ~`MRF_WMASK_QUEUE);
            end
            if (wr_fan) begin
                fan_r   <= (reg_wdata_i & `MRF_WMASK_FAN) | (fan_r & ~`MRF_WMASK_FAN);
            end
            if (wr_mask) begin
                mask_r  <= (reg_wdata_i & `MRF_WMASK_MASK) | (mask_r & ~`MRF_WMASK_MASK);
            end
        end
    end

    // Read data is registered: it follows the address by one cycle
    assign rd_mux = (reg_addr_i == `MRF_ADDR_RATE)  ? rate_r  :
                    (reg_addr_i == `MRF_ADDR_QUEUE) ? queue_r :
                    (reg_addr_i == `MRF_ADDR_FAN)   ? fan_r   :
                    (reg_addr_i == `MRF_ADDR_MASK)  ? mask_r  : 8'h00;

    // Rate timer; bit 7 of the rate register is stored but never steers it
    mrf_rate_if rate_link ();
    assign rate_link.rate_code   = rate_r[`MRF_RATE_LSB +: 4];
    assign rate_link.round_start = round_start_i;
    assign active_rate_o         = rate_link.active_rate;
    assign conv_tick_o           = rate_link.conv_tick;

    mrf_rate_timer #(
        .SLOW_PERIOD_CYC (SLOW_PERIOD_CYC)
    ) u_rate_timer (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .rate       (rate_link.timer)
    );

    // Consecutive out-of-limit count, saturating at the deepest queue
    assign need_w = queue_need(queue_r[3:0]);

    // Fan source and forced states; fan-off outranks full speed
    assign fan_off_w = fan_r[`MRF_FAN_OFF_BIT];
    assign sel_w     = mrf_drive_sel_type'(fan_r[`MRF_FAN_SEL_LSB +: 2]);
    assign drive_nxt = fan_off_w                ? 8'h00 :
                       (sel_w == MRF_SRC_FULL)  ? 8'hff :
                       (sel_w == MRF_SRC_LOCAL) ? local_speed_i : remote_speed_i;

    // Masked sources keep their status but never raise the output
    assign int_nxt = |(status_i & ~mask_r[`MRF_MASK_LSB +: 5]);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r     <= 8'h00;
            fault_cnt_r <= 3'd0;
            int_r       <= 1'b0;
            drive_r     <= 8'h00;
        end else begin
            rdata_r <= rd_mux;
            int_r   <= int_nxt;
            drive_r <= drive_nxt;
            if (meas_done_i && !meas_out_i) begin
                fault_cnt_r <= 3'd0;
            end else if (meas_done_i && (fault_cnt_r != 3'd4)) begin
                fault_cnt_r <= fault_cnt_r + 3'd1;
            end
        end
    end

    assign reg_rdata_o   = rdata_r;
    assign fault_need_o  = need_w;
    assign fault_alert_o = (fault_cnt_r >= need_w);
    assign int_o         = int_r;
    assign fan_drive_o   = drive_r;

    chk_lock_blocks_rate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        reg_wr_i && lock_i && !soft_restore_i && (reg_addr_i == `MRF_ADDR_RATE)
        |=> $stable(rate_r))
        else $error("Locked rate register accepted a write");

    chk_mask_not_locked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        reg_wr_i && lock_i && !soft_restore_i && (reg_addr_i == `MRF_ADDR_MASK)
        |=> mask_r[7:3] == $past(reg_wdata_i[7:3]))
        else $error("Mask write lost while locked");

    chk_soft_defaults: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        soft_restore_i |=> (rate_r == 8'h00) && (queue_r == 8'h01)
                           && (fan_r == 8'h09) && (mask_r == 8'h52))
        else $error("Soft restore did not load defaults");

    chk_fan_off_stops: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        fan_r[6] |=> (fan_drive_o == 8'h00))
        else $error("Fan not stopped while fan-off set");

    chk_fan_source_sel: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !fan_r[6] && (fan_r[1:0] != 2'b11)
        |=> fan_drive_o == (($past(fan_r[1:0]) == 2'b00) ? $past(local_speed_i)
                                                         : $past(remote_speed_i)))
        else $error("Fan drive follows the wrong temperature source");

    chk_fan_full_speed: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !fan_r[6] && (fan_r[1:0] == 2'b11) |=> (fan_drive_o == 8'hff))
        else $error("Fan not at full speed for code 11");

    chk_int_masked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ((status_i & ~mask_r[7:3]) == 5'h00) |=> !int_o)
        else $error("Masked status raised the interrupt");

    chk_queue_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        meas_done_i && meas_out_i && (queue_r[3:0] == 4'h8) && (fault_cnt_r == 3'd0)
        && !soft_restore_i && !wr_queue
        |=> !fault_alert_o ##0 fault_cnt_r == 3'd1)
        else $error("Alert raised before the queue depth was reached");

    chk_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (reg_addr_i == `MRF_ADDR_QUEUE) |=> (reg_rdata_o[7:4] == 4'h0))
        else $error("Reserved queue bits read non-zero");

endmodule // mrf_regs

//--- pkg/mrf_params.svh
// Offsets, field positions, reset values and timing counts of the monitor control registers.
// Assumes an 8-bit register port with byte offsets; included by its bare name.
`ifndef MRF_PARAMS_SVH
`define MRF_PARAMS_SVH

`define MRF_ADDR_RATE        8'h04
`define MRF_ADDR_QUEUE       8'h06
`define MRF_ADDR_FAN         8'h07
`define MRF_ADDR_MASK        8'h08

`define MRF_RST_RATE         8'h00
`define MRF_RST_QUEUE        8'h01
`define MRF_RST_FAN          8'h09
`define MRF_RST_MASK         8'h52

// Bits that a host write may change; all others hold their reset value
`define MRF_WMASK_RATE       8'h8f
`define MRF_WMASK_QUEUE      8'h0f
`define MRF_WMASK_FAN        8'h43
`define MRF_WMASK_MASK       8'hf8

`define MRF_RATE_LSB         0
`define MRF_RATE_MAX         4'ha
`define MRF_FAN_OFF_BIT      6
`define MRF_FAN_SEL_LSB      0
`define MRF_MASK_LSB         3

`define MRF_CLK_HZ           10000000
`define MRF_SLOW_PERIOD_MS   16000
`define MRF_SLOW_PERIOD_CYC  ((`MRF_CLK_HZ / 1000) * `MRF_SLOW_PERIOD_MS)

`endif

//--- pkg/mrf_pkg.sv
// Types shared by the monitor control register bank and its rate timer.
// Holds no constants; those live in mrf_params.svh.
package mrf_pkg;

    typedef enum logic [1:0] {
        MRF_SRC_LOCAL    = 2'b00,
        MRF_SRC_REMOTE_A = 2'b01,
        MRF_SRC_REMOTE_B = 2'b10,
        MRF_SRC_FULL     = 2'b11
    } mrf_drive_sel_type;

    typedef logic [7:0] mrf_byte_type;

endpackage

//--- pkg/mrf_rate_if.sv
// Link between the register bank and the conversion rate timer.
// Both ends run on the same clock.
`timescale 1ns/1ns
interface mrf_rate_if;
    logic [3:0] rate_code;
    logic       round_start;
    logic [3:0] active_rate;
    logic       conv_tick;

    modport ctrl  (output rate_code, output round_start, input active_rate, input conv_tick);
    modport timer (input rate_code, input round_start, output active_rate, output conv_tick);
endinterface

//--- rtl/mrf_rate_timer.sv
// Conversion rate timer: holds the rate in force and emits one tick per conversion.
// Assumes round_start comes from the measurement sequencer on the same clock.
`timescale 1ns/1ns
`include "mrf_params.svh"
module mrf_rate_timer
    import mrf_pkg::*;
#(
    parameter int SLOW_PERIOD_CYC = `MRF_SLOW_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // Link to the register bank
    mrf_rate_if.timer rate
);

    generate
        if (SLOW_PERIOD_CYC < 1024) begin : g_bad_period
            $error("SLOW_PERIOD_CYC must be at least 1024");
        end
    endgenerate

    logic [3:0]  active_r;
    logic [31:0] count_r;
    logic [3:0]  code_clamped;
    logic [31:0] period_w;
    logic        wrap_w;

    // Codes above the fastest rate are undefined; they run at the fastest rate
    assign code_clamped = (rate.rate_code > `MRF_RATE_MAX) ? `MRF_RATE_MAX : rate.rate_code;
    assign period_w     = 32'(SLOW_PERIOD_CYC) >> active_r;
    assign wrap_w       = (count_r == period_w - 32'h1);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_r <= 4'h0;
            count_r  <= 32'h0;
        end else begin
            if (rate.round_start) begin
                active_r <= code_clamped;
                count_r  <= 32'h0;
            end else if (wrap_w) begin
                count_r  <= 32'h0;
            end else begin
                count_r  <= count_r + 32'h1;
            end
        end
    end

    assign rate.active_rate = active_r;
    assign rate.conv_tick   = wrap_w && !rate.round_start;

    // Helper: cycles since the last tick or boundary
    logic [31:0] since_r;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since_r <= 32'h0;
        end else if (rate.conv_tick || rate.round_start) begin
            since_r <= 32'h0;
        end else begin
            since_r <= since_r + 32'h1;
        end
    end

    chk_rate_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !$past(rate.round_start) |-> $stable(active_r))
        else $error("Rate changed outside a round-robin boundary");

    chk_rate_period: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rate.conv_tick |-> (since_r == (32'(SLOW_PERIOD_CYC) >> active_r) - 32'h1))
        else $error("Conversion tick spacing does not match the active rate");

endmodule // mrf_rate_timer

//--- testbench/mrf_host_model.sv
// Host side of the register port: one-cycle byte writes and registered reads.
// Assumes the bank samples every input on the rising edge of core_clk_i.
`timescale 1ns/1ns
`include "mrf_params.svh"
module mrf_host_model (
    // Clock
    input  wire logic       core_clk_i,
    // Register port toward the bank
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // Called just after an edge; holds the request through the next edge,
    // then idles one edge so back-to-back writes never glitch the strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_o  = a;
        reg_wr_o    = 1'b1;
        reg_wdata_o = (a == `MRF_ADDR_RATE) ? (d & 8'h7f) : d;
        @(posedge core_clk_i);
        #10;
        reg_wr_o    = 1'b0;
        // Stale data is inverted so a late sample never looks right
        reg_wdata_o = ~reg_wdata_o;
        @(posedge core_clk_i);
        #10;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr_o = a;
        @(posedge core_clk_i);
        #10;
        d = reg_rdata_i;
    endtask
endmodule // mrf_host_model

//--- testbench/tb.sv
// Self-checking bench for the monitor control register bank.
// Assumes mrf_regs, mrf_pkg and mrf_params.svh are compiled first.
`timescale 1ns/1ns
`include "mrf_params.svh"
module tb;
    import mrf_pkg::*;
    // Short slow period keeps the rate sweep within a few thousand cycles
    localparam int SLOW = 2048;
    logic       core_clk_i, rst_n_i, lock_i, soft_restore_i, round_start_i;
    logic       meas_done_i, meas_out_i, reg_wr, conv_tick_o, fault_alert_o, int_o;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, local_speed_i, remote_speed_i, fan_drive_o;
    logic [3:0] active_rate_o;
    logic [2:0] fault_need_o;
    logic [4:0] status_i;
    logic [7:0] v;
    int         err_count, samples_checked, act, run, need, n;
    int         mdl [4];
    int         outs[$];
    logic [7:0] adr [4] = '{`MRF_ADDR_RATE, `MRF_ADDR_QUEUE, `MRF_ADDR_FAN, `MRF_ADDR_MASK};
    logic [7:0] rst [4] = '{`MRF_RST_RATE, `MRF_RST_QUEUE, `MRF_RST_FAN, `MRF_RST_MASK};
    logic [7:0] wm  [4] = '{8'h0f, `MRF_WMASK_QUEUE, `MRF_WMASK_FAN, `MRF_WMASK_MASK};

    mrf_host_model host (.core_clk_i(core_clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));
    mrf_regs #(.SLOW_PERIOD_CYC(SLOW)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .lock_i(lock_i), .soft_restore_i(soft_restore_i),
        .round_start_i(round_start_i), .meas_done_i(meas_done_i), .meas_out_i(meas_out_i),
        .active_rate_o(active_rate_o), .conv_tick_o(conv_tick_o),
        .fault_need_o(fault_need_o), .fault_alert_o(fault_alert_o), .status_i(status_i),
        .int_o(int_o), .local_speed_i(local_speed_i), .remote_speed_i(remote_speed_i),
        .fan_drive_o(fan_drive_o));

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic step();
        @(posedge core_clk_i);
        #10;
    endtask
    // Model follows lock: only the mask stays writable while locked
    task automatic wr(input int i, input logic [7:0] d);
        host.wr(adr[i], d);
        if (!(lock_i && i < 3)) mdl[i] = (mdl[i] & ~wm[i]) | (d & wm[i]);
    endtask
    task automatic rd_all();
        for (int i = 0; i < 4; i++) begin
            host.rd(adr[i], v);
            check("register", v, mdl[i][7:0]);
        end
    endtask
    task automatic meas(input logic o);
        meas_done_i = 1'b1;
        meas_out_i  = o;
        outs.push_back(o);
        run = o ? ((run < 4) ? run + 1 : 4) : 0;
        step();
    endtask
    task automatic wait_tick();
        n = 0;
        do begin
            step();
            n++;
            if (n > 3000) begin
                err_count++;
                close_out();
            end
        end while (conv_tick_o !== 1'b1);
    endtask

    initial begin
        {lock_i, soft_restore_i, round_start_i, meas_done_i, meas_out_i} = 5'h00;
        {local_speed_i, remote_speed_i, status_i} = 21'h0;
        rst_n_i = 1'b0;
        void'($urandom(32'h35cb1f13));
        for (int i = 0; i < 4; i++) mdl[i] = rst[i];
        repeat (3) @(posedge core_clk_i);
        #10;
        rst_n_i = 1'b1;
        rd_all();
        host.rd(8'h05, v);
        check("unmapped", v, 8'h00);
        for (int i = 0; i < 4; i++) wr(i, 8'hff);
        rd_all();
        for (int i = 0; i < 4; i++) wr(i, 8'h00);
        rd_all();
        $display("test access done");
        lock_i = 1'b1;
        for (int i = 0; i < 4; i++) wr(i, 8'($urandom));
        rd_all();
        lock_i = 1'b0;
        for (int i = 0; i < 4; i++) wr(i, 8'($urandom));
        soft_restore_i = 1'b1;
        step();
        soft_restore_i = 1'b0;
        for (int i = 0; i < 4; i++) mdl[i] = rst[i];
        rd_all();
        $display("test lock and restore done");
        act = 0;
        for (int c = 0; c < 13; c++) begin
            if (c == 11) continue;
            wr(0, 8'(c));
            check("rate held", 8'(active_rate_o), 8'(act));
            round_start_i = 1'b1;
            step();
            round_start_i = 1'b0;
            act = (c > 10) ? 10 : c;
            check("rate active", 8'(active_rate_o), 8'(act));
            wait_tick();
            wait_tick();
            check("tick period", 8'(n), 8'((SLOW >> act) & 8'hff));
            check("period high", 8'(n >> 8), 8'((SLOW >> act) >> 8));
        end
        $display("test rate done");
        for (int q = 0; q < 16; q++) begin
            wr(1, 8'(q));
            need = q[3] ? 4 : q[2] ? 3 : q[1] ? 2 : 1;
            check("fault need", 8'(fault_need_o), 8'(need));
            for (int k = 0; k < need; k++) begin
                meas(1'b1);
                check("alert", 8'(fault_alert_o), 8'(run >= need));
            end
            meas(1'b0);
            meas_done_i = 1'b0;
            check("alert clear", 8'(fault_alert_o), 8'h00);
        end
        $display("test fault queue done, %0d measurements", outs.size());
        for (int f = 0; f < 8; f++) begin
            wr(2, {1'b0, f[2], 4'h0, f[1:0]});
            local_speed_i  = 8'($urandom);
            remote_speed_i = 8'($urandom);
            step();
            v = f[2] ? 8'h00 : (f[1:0] == 0) ? local_speed_i : (f[1:0] == 3) ? 8'hff
                : remote_speed_i;
            check("fan drive", fan_drive_o, v);
        end
        $display("test fan done");
        for (int r = 0; r < 24; r++) begin
            wr(3, 8'($urandom));
            status_i = 5'($urandom);
            step();
            check("interrupt", 8'(int_o), 8'(|(status_i & ~mdl[3][7:3])));
        end
        $display("test mask done");
        close_out();
    end
endmodule // tb
